// File: hdl/timer_capture_event_square_pkg.sv
// Constants, carriers and decode helpers for the capture/compare timer
package timer_capture_event_square_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;

    localparam logic [ADDR_W-1:0] OFS_COUNTER  = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CAPCMP_A = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CAPCMP_B = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_MODE     = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_CC_CTRL  = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_OUT_CTRL = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h1C;

    localparam int MODE_OVF_BIT   = 0;
    localparam int MODE_RUN_LO    = 2;
    localparam int PRE_CLK_LO     = 0;
    localparam int PRE_EDGE_A_LO  = 4;
    localparam int PRE_EDGE_B_LO  = 6;
    localparam int CC_A_CAP_BIT   = 0;
    localparam int CC_A_SRC_BIT   = 1;
    localparam int CC_B_CAP_BIT   = 2;
    localparam int OUT_ENABLE_BIT = 0;
    localparam int OUT_TOGGLE_BIT = 1;
    localparam int ST_MATCH_A_BIT = 0;
    localparam int ST_CAP_B_BIT   = 1;

    localparam logic [1:0] RUN_STOP        = 2'h0;
    localparam logic [1:0] RUN_RESTART     = 2'h1;
    localparam logic [1:0] RUN_FREE        = 2'h2;
    localparam logic [1:0] RUN_MATCH_CLEAR = 2'h3;

    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam logic [1:0] CLK_EVENT = 2'h3;

    localparam logic [7:0]        RST_CTRL    = 8'h00;
    localparam logic [DATA_W-1:0] RST_CAPCMP  = 16'h0000;
    localparam logic [DATA_W-1:0] COUNTER_MAX = 16'hFFFF;

    // Count clock divide exponents for selections 0..2, filter clock /2^2
    localparam int DIV_SHIFT_0      = 1;
    localparam int DIV_SHIFT_1      = 3;
    localparam int DIV_SHIFT_2      = 6;
    localparam int FILTER_DIV_SHIFT = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_type;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } filter_out_type;

    typedef struct packed {
        logic count_rise;
        logic count_fall;
        logic filter_tick;
    } tick_type;

    function automatic logic edge_valid(input logic [1:0] sel, input filter_out_type f);
        edge_valid = (f.rise && (sel == EDGE_RISE || sel == EDGE_BOTH))
                  || (f.fall && (sel == EDGE_FALL || sel == EDGE_BOTH));
    endfunction

endpackage

// File: hdl/count_prescaler.sv
// Count clock and filter sampling tick generator
module count_prescaler
    import timer_capture_event_square_pkg::*;
#(
    parameter int CNT_W   = 8,
    parameter int SHIFT_0 = DIV_SHIFT_0,
    parameter int SHIFT_1 = DIV_SHIFT_1,
    parameter int SHIFT_2 = DIV_SHIFT_2,
    parameter int SHIFT_F = FILTER_DIV_SHIFT
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] sel_in,
    output tick_type        tick_out
);

    initial begin
        if (SHIFT_0 < 1 || SHIFT_1 < 1 || SHIFT_2 < 1 || SHIFT_F < 1
            || SHIFT_0 >= CNT_W || SHIFT_1 >= CNT_W || SHIFT_2 >= CNT_W
            || SHIFT_F >= CNT_W) begin
            $error("count_prescaler: divide exponent out of range");
        end
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        tick_type         tick;
    } pre_state_type;

    pre_state_type s;
    pre_state_type next_s;

    function automatic logic [CNT_W-1:0] low_mask(input int sh);
        low_mask = CNT_W'((1 << sh) - 1);
    endfunction

    // Free running divider: the count phase is not tied to timer start
    always_comb begin
        logic [CNT_W-1:0] m;
        m = '0;
        next_s = s;
        next_s.cnt = s.cnt + 1'b1;
        unique case (sel_in)
            2'h0:    m = low_mask(SHIFT_0);
            2'h1:    m = low_mask(SHIFT_1);
            default: m = low_mask(SHIFT_2);
        endcase
        next_s.tick.count_rise  = (s.cnt & m) == '0;
        next_s.tick.count_fall  = (s.cnt & m) == ((m >> 1) + 1'b1);
        next_s.tick.filter_tick = (s.cnt & low_mask(SHIFT_F)) == '0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

endmodule

// File: hdl/edge_filter.sv
// Two-sample noise filter with edge pulses
module edge_filter
    import timer_capture_event_square_pkg::*;
(
    input  wire logic     clk_in,
    input  wire logic     rst_n_in,
    input  wire logic     raw_in,
    input  wire logic     sample_in,
    input  wire logic     enable_in,
    output filter_out_type filt_out
);

    typedef struct packed {
        logic           prev;
        logic           ran;
        filter_out_type f;
    } filt_state_type;

    filt_state_type s;
    filt_state_type next_s;

    always_comb begin
        next_s = s;
        next_s.f.rise = 1'b0;
        next_s.f.fall = 1'b0;
        if (enable_in) begin
            next_s.ran = 1'b1;
            if (sample_in) begin
                next_s.prev = raw_in;
                if (raw_in == s.prev && raw_in != s.f.level) begin
                    next_s.f.level = raw_in;
                    next_s.f.rise  = raw_in;
                    next_s.f.fall  = !raw_in;
                end
            end
        end else if (s.ran) begin
            // Tracks the pin while stopped, so a restart sees no edge
            next_s.prev    = raw_in;
            next_s.f.level = raw_in;
        end
    end

    // Level starts low: a pin already high shows one rise at first enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign filt_out = s.f;

endmodule

// File: hdl/timer_capture_event_square.sv
// 16-bit timer with two capture/compare registers, event count and square wave
//
// Added by the designer: the register offsets and the plain strobed port.
module timer_capture_event_square
    import timer_capture_event_square_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [DATA_W-1:0] rdata_out,
    input  wire logic              capture_input_a_in,
    input  wire logic              capture_input_b_in,
    output logic                   timer_output_pin_out,
    output logic                   timer_output_pin_oe_n_out,
    output logic                   match_a_irq_out,
    output logic                   capcmp_irq_b_out
);

    typedef struct packed {
        logic [DATA_W-1:0] main_counter;
        logic [DATA_W-1:0] capcmp_reg_a;
        logic [DATA_W-1:0] capcmp_reg_b;
        logic [1:0]        run_mode;
        logic              overflow_flag;
        logic              ovf_hold;
        logic [7:0]        prescale_edge_select_reg;
        logic [2:0]        capcmp_control_reg;
        logic [1:0]        output_control_reg;
        logic              flag_match_a;
        logic              capture_b_irq_flag;
        logic              pend_a;
        logic              pend_b;
        logic              meta_a;
        logic              sync_a;
        logic              meta_b;
        logic              sync_b;
        logic [DATA_W-1:0] rdata;
        logic              match_a_irq;
        logic              irq_b;
        logic              tout;
        logic              tout_oe_n;
    } state_type;

    logic [1:0]     rst_sync;
    logic           rst_n;
    state_type      s;
    state_type      next_s;
    bus_req_type    req;
    tick_type       tick;
    filter_out_type filt_a;
    filter_out_type filt_b;
    logic           running;
    logic           event_mode;
    logic [1:0]     edge_sel_a;
    logic [1:0]     edge_sel_b;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign req        = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign running    = s.run_mode != RUN_STOP;
    assign event_mode = s.prescale_edge_select_reg[PRE_CLK_LO +: 2] == CLK_EVENT;
    assign edge_sel_a = s.prescale_edge_select_reg[PRE_EDGE_A_LO +: 2];
    assign edge_sel_b = s.prescale_edge_select_reg[PRE_EDGE_B_LO +: 2];

    count_prescaler u_prescaler (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_n),
        .sel_in   (s.prescale_edge_select_reg[PRE_CLK_LO +: 2]),
        .tick_out (tick)
    );

    // Event mode samples on the fixed clock, capture on count clock fall
    edge_filter u_filter_a (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n),
        .raw_in    (s.sync_a),
        .sample_in (event_mode ? tick.filter_tick : tick.count_fall),
        .enable_in (running),
        .filt_out  (filt_a)
    );

    edge_filter u_filter_b (
        .clk_in    (ref_clk_in),
        .rst_n_in  (rst_n),
        .raw_in    (s.sync_b),
        .sample_in (tick.count_fall),
        .enable_in (running),
        .filt_out  (filt_b)
    );

    always_comb begin
        logic edge_a;
        logic edge_b;
        logic inv_a;
        logic advance;
        logic matched;
        edge_a  = edge_valid(edge_sel_a, filt_a);
        edge_b  = edge_valid(edge_sel_b, filt_b);
        inv_a   = (edge_sel_a == EDGE_RISE && filt_a.fall)
               || (edge_sel_a == EDGE_FALL && filt_a.rise);
        advance = running && (event_mode ? edge_a : tick.count_rise);
        matched = 1'b0;

        next_s             = s;
        next_s.meta_a      = capture_input_a_in;
        next_s.sync_a      = s.meta_a;
        next_s.meta_b      = capture_input_b_in;
        next_s.sync_b      = s.meta_b;
        next_s.match_a_irq = 1'b0;
        next_s.irq_b       = 1'b0;
        next_s.rdata       = '0;

        // Read returns pre-capture contents; counter read has no side effect
        if (req.rd) begin
            unique case (req.addr)
                OFS_COUNTER:  next_s.rdata = s.main_counter;
                OFS_CAPCMP_A: next_s.rdata = s.capcmp_reg_a;
                OFS_CAPCMP_B: next_s.rdata = s.capcmp_reg_b;
                OFS_MODE:     next_s.rdata = DATA_W'({s.run_mode, 1'b0, s.overflow_flag});
                OFS_PRESCALE: next_s.rdata = DATA_W'(s.prescale_edge_select_reg);
                OFS_CC_CTRL:  next_s.rdata = DATA_W'(s.capcmp_control_reg);
                OFS_OUT_CTRL: next_s.rdata = DATA_W'(s.output_control_reg);
                OFS_STATUS:   next_s.rdata = DATA_W'({s.capture_b_irq_flag, s.flag_match_a});
                default:      next_s.rdata = '0;
            endcase
        end

        if (req.wr) begin
            unique case (req.addr)
                OFS_CAPCMP_A: next_s.capcmp_reg_a = req.wdata;
                OFS_CAPCMP_B: next_s.capcmp_reg_b = req.wdata;
                OFS_MODE: begin
                    next_s.run_mode = req.wdata[MODE_RUN_LO +: 2];
                    if (!req.wdata[MODE_OVF_BIT] && !s.ovf_hold) begin
                        next_s.overflow_flag = 1'b0;
                    end
                end
                OFS_PRESCALE: next_s.prescale_edge_select_reg = req.wdata[7:0];
                OFS_CC_CTRL:  next_s.capcmp_control_reg = req.wdata[2:0];
                OFS_OUT_CTRL: next_s.output_control_reg = req.wdata[1:0];
                OFS_STATUS: begin
                    if (req.wdata[ST_MATCH_A_BIT]) begin
                        next_s.flag_match_a = 1'b0;
                    end
                    if (req.wdata[ST_CAP_B_BIT]) begin
                        next_s.capture_b_irq_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Hardware updates follow the bus so a capture beats a write
        if (!running) begin
            next_s.main_counter = '0;
            next_s.pend_a       = 1'b0;
            next_s.pend_b       = 1'b0;
            next_s.ovf_hold     = 1'b0;
        end else if (s.run_mode == RUN_RESTART && !event_mode && edge_a
                     && edge_sel_a != EDGE_BOTH) begin
            next_s.capcmp_reg_b = s.main_counter;
            next_s.main_counter = '0;
            next_s.pend_b       = 1'b1;
        end else if (advance) begin
            next_s.ovf_hold = 1'b0;
            if (s.main_counter == COUNTER_MAX
                && (s.run_mode == RUN_FREE || s.capcmp_reg_a == COUNTER_MAX)) begin
                next_s.overflow_flag = 1'b1;
                next_s.ovf_hold      = 1'b1;
            end
            // Equality only: a compare value below the count waits for wrap
            if ((s.run_mode == RUN_MATCH_CLEAR || event_mode)
                && !s.capcmp_control_reg[CC_A_CAP_BIT]
                && s.main_counter == s.capcmp_reg_a) begin
                matched             = 1'b1;
                next_s.main_counter = '0;
            end else begin
                next_s.main_counter = s.main_counter + 1'b1;
            end
            if (!s.capcmp_control_reg[CC_B_CAP_BIT]
                && s.main_counter == s.capcmp_reg_b) begin
                next_s.irq_b              = 1'b1;
                next_s.capture_b_irq_flag = 1'b1;
            end
        end

        // Free and match-clear captures; none while the pin clocks the count
        if (running && s.run_mode != RUN_RESTART && !event_mode) begin
            if (s.capcmp_control_reg[CC_B_CAP_BIT] && edge_a) begin
                next_s.capcmp_reg_b = s.main_counter;
                next_s.pend_b       = 1'b1;
            end
            if (s.capcmp_control_reg[CC_A_CAP_BIT] && edge_sel_a != EDGE_BOTH
                && (s.capcmp_control_reg[CC_A_SRC_BIT] ? inv_a : edge_b)) begin
                next_s.capcmp_reg_a = s.main_counter;
                next_s.pend_a       = 1'b1;
            end
        end

        if (matched) begin
            next_s.match_a_irq  = 1'b1;
            next_s.flag_match_a = 1'b1;
            if (!event_mode && s.output_control_reg == 2'h3) begin
                next_s.tout = !s.tout;
            end
        end

        // Captures land on the fall phase, their requests on the next rise
        if (running && tick.count_rise) begin
            if (s.pend_a) begin
                next_s.match_a_irq  = 1'b1;
                next_s.flag_match_a = 1'b1;
                next_s.pend_a       = 1'b0;
            end
            if (s.pend_b) begin
                next_s.irq_b              = 1'b1;
                next_s.capture_b_irq_flag = 1'b1;
                next_s.pend_b             = 1'b0;
            end
        end

        // Pin is an input while it clocks the event counter
        next_s.tout_oe_n = !(next_s.output_control_reg[OUT_ENABLE_BIT]
                           && next_s.prescale_edge_select_reg[PRE_CLK_LO +: 2] != CLK_EVENT);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{
                main_counter:             RST_CAPCMP,
                capcmp_reg_a:             RST_CAPCMP,
                capcmp_reg_b:             RST_CAPCMP,
                prescale_edge_select_reg: RST_CTRL,
                tout_oe_n:                1'b1,
                default:                  '0
            };
        end else begin
            s <= next_s;
        end
    end

    assign rdata_out                 = s.rdata;
    assign timer_output_pin_out      = s.tout;
    assign timer_output_pin_oe_n_out = s.tout_oe_n;
    assign match_a_irq_out           = s.match_a_irq;
    assign capcmp_irq_b_out          = s.irq_b;

endmodule

// File: verif/timer_capture_event_square_monitor.sv
// Port-level timer checker
module timer_capture_event_square_monitor
    import timer_capture_event_square_pkg::*;
(
    input logic              ref_clk_in,
    input logic              arst_n_in,
    input logic [ADDR_W-1:0] addr_in,
    input logic [DATA_W-1:0] wdata_in,
    input logic              wr_in,
    input logic              rd_in,
    input logic [DATA_W-1:0] rdata_out,
    input logic              timer_output_pin_out,
    input logic              timer_output_pin_oe_n_out,
    input logic              match_a_irq_out,
    input logic              capcmp_irq_b_out
);
    // Shadow of software writes
    logic [DATA_W-1:0] sh_a;
    logic [DATA_W-1:0] sh_b;
    logic              a_ok;
    logic              b_ok;
    logic [7:0]        sh_pre;
    logic [2:0]        sh_cc;
    logic [1:0]        sh_out;
    logic [1:0]        sh_run;
    logic [6:0]        settle;
    logic              ev;
    logic              w_a;
    logic              w_b;

    assign ev = sh_pre[1:0] == CLK_EVENT;
    assign w_a = wr_in && addr_in == OFS_CAPCMP_A;
    assign w_b = wr_in && addr_in == OFS_CAPCMP_B;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sh_a <= RST_CAPCMP;
            sh_b <= RST_CAPCMP;
            a_ok <= 1'b1;
            b_ok <= 1'b1;
            sh_pre <= 8'h00;
            sh_cc <= 3'h0;
            sh_out <= 2'h0;
            sh_run <= RUN_STOP;
            settle <= 7'h00;
        end else begin
            settle <= wr_in ? 7'h00 : settle + {6'h00, settle != 7'h7F};
            sh_a <= w_a ? wdata_in : sh_a;
            sh_b <= w_b ? wdata_in : sh_b;
            // Captures overwrite the shadow
            a_ok <= w_a || (a_ok && !sh_cc[CC_A_CAP_BIT]);
            b_ok <= w_b || (b_ok && !sh_cc[CC_B_CAP_BIT] && sh_run != RUN_RESTART);
            sh_pre <= (wr_in && addr_in == OFS_PRESCALE) ? wdata_in[7:0] : sh_pre;
            sh_cc <= (wr_in && addr_in == OFS_CC_CTRL) ? wdata_in[2:0] : sh_cc;
            sh_out <= (wr_in && addr_in == OFS_OUT_CTRL) ? wdata_in[1:0] : sh_out;
            sh_run <= (wr_in && addr_in == OFS_MODE) ? wdata_in[MODE_RUN_LO +: 2] : sh_run;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
        else $error("stray read data");
    unmapped_read_a: assert property (rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == '0)
        else $error("unmapped read data");
    irq_a_pulse_a: assert property (match_a_irq_out |=> !match_a_irq_out)
        else $error("long match A pulse");
    irq_b_pulse_a: assert property (capcmp_irq_b_out |=> !capcmp_irq_b_out)
        else $error("long B pulse");
    oe_state_a: assert property (settle >= 7'h03
        |-> timer_output_pin_oe_n_out == !(sh_out[OUT_ENABLE_BIT] && !ev))
        else $error("pin enable wrong");
    toggle_hold_a: assert property (settle >= 7'h03 && !sh_out[OUT_TOGGLE_BIT]
        |=> $stable(timer_output_pin_out))
        else $error("toggle while off");
    stop_quiet_a: assert property (settle == 7'h7F && sh_run == RUN_STOP
        |-> !match_a_irq_out && !capcmp_irq_b_out)
        else $error("irq while stopped");
    both_edge_a: assert property (settle == 7'h7F && sh_pre[5:4] == EDGE_BOTH && !ev
        && sh_cc[CC_A_CAP_BIT] && sh_run != RUN_STOP |-> !match_a_irq_out)
        else $error("A capture on both");
    event_space_a: assert property (match_a_irq_out && ev
        |=> !match_a_irq_out [*7])
        else $error("events too close");
    cmp_a_read_a: assert property (rd_in && addr_in == OFS_CAPCMP_A && a_ok
        && settle >= 7'h02 |=> rdata_out == sh_a)
        else $error("A readback wrong");
    cmp_b_read_a: assert property (rd_in && addr_in == OFS_CAPCMP_B && b_ok
        && settle >= 7'h02 |=> rdata_out == sh_b)
        else $error("B readback wrong");
endmodule

bind timer_capture_event_square timer_capture_event_square_monitor u_monitor (
    .ref_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .timer_output_pin_out,
    .timer_output_pin_oe_n_out, .match_a_irq_out, .capcmp_irq_b_out
);

// File: verif/pulse_partner.sv
// Capture pulse source and timer pin watcher
module pulse_partner (
    input  wire logic clk_in,
    input  wire logic pin_in,
    input  wire logic pin_oe_n_in,
    output logic      cap_a_out,
    output logic      cap_b_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int   cyc = 0;
    int   last_t = 0;
    int   period = 0;
    int   toggles = 0;
    logic prev = 1'b1;
    logic lvl;

    // Released pin reads its pull-up
    assign lvl = pin_oe_n_in ? 1'b1 : pin_in;

    initial begin
        // Pulled-up input: high from reset on
        cap_a_out = 1'b1;
        cap_b_out = 1'b0;
    end

    task automatic set_a(input logic v);
        @(posedge clk_in);
        cap_a_out <= v;
    endtask

    // Each phase w clocks, two phases over 2w+1 clocks
    task automatic pulse_a(input int w);
        set_a(!cap_a_out);
        repeat (w) @(posedge clk_in);
        cap_a_out <= !cap_a_out;
        repeat (w) @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (lvl !== prev) begin
            period <= cyc - last_t;
            last_t <= cyc;
            toggles <= toggles + 1;
        end
        prev <= lvl;
    end
endmodule

// File: verif/tb_top.sv
// Self-checking timer bench
module tb_top
    import timer_capture_event_square_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] v;
    logic              cap_a;
    logic              cap_b;
    logic              pin;
    logic              pin_oe_n;
    logic              irq_a;
    logic              irq_b;
    int                error_cnt = 0;
    int                n_checks = 0;
    int                seed = 32'hB168;
    int                cnt_a = 0;
    int                cnt_b = 0;

    always #12.5 clk = ~clk;

    timer_capture_event_square dut (
        .ref_clk_in(clk), .arst_n_in(arst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .capture_input_a_in(cap_a),
        .capture_input_b_in(cap_b), .timer_output_pin_out(pin),
        .timer_output_pin_oe_n_out(pin_oe_n), .match_a_irq_out(irq_a),
        .capcmp_irq_b_out(irq_b)
    );
    pulse_partner partner (
        .clk_in(clk), .pin_in(pin), .pin_oe_n_in(pin_oe_n), .cap_a_out(cap_a),
        .cap_b_out(cap_b)
    );

    always @(posedge clk) begin
        cnt_a <= cnt_a + int'(irq_a === 1'b1);
        cnt_b <= cnt_b + int'(irq_b === 1'b1);
    end

    function automatic logic [DATA_W-1:0] mode(input logic [1:0] r);
        return {12'h000, r, 2'h0};
    endfunction
    function automatic logic [DATA_W-1:0] pre(input logic [1:0] e, input logic [1:0] c);
        return {10'h000, e, 2'h0, c};
    endfunction

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Polling B lets reads meet captures
    task automatic wait_b(input int lim, output int took);
        int c0;
        c0 = cnt_b;
        took = 0;
        while (cnt_b == c0 && took < lim) begin
            bus_rd(OFS_CAPCMP_B, d);
            took += 2;
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Run needs about 2000 clocks
    initial begin
        idle(40000);
        error_cnt++;
        close_out();
    end

    // Overflow takes 131k clocks: untested
    initial begin
        logic [1:0] eg[3];
        int         took;
        int         w;
        int         a0;
        int         b0;
        int         n;
        eg = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
        idle(8);
        arst_n <= 1'b1;
        idle(3);
        chk(16'(pin_oe_n), 16'h1);
        for (int i = 0; i < 9; i++) begin
            bus_rd(i == 8 ? 5'h06 : ADDR_W'(4 * i), d);
            chk(d, 16'h0);
        end
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            bus_wr(i[0] ? OFS_CAPCMP_B : OFS_CAPCMP_A, v);
            bus_rd(i[0] ? OFS_CAPCMP_B : OFS_CAPCMP_A, d);
            chk(d, v);
        end
        bus_wr(OFS_PRESCALE, pre(EDGE_RISE, 2'h0));
        bus_wr(OFS_CC_CTRL, 16'h0004);
        bus_wr(OFS_MODE, mode(RUN_RESTART));
        wait_b(60, took);
        chk(16'(took < 60), 16'h1);
        bus_wr(OFS_MODE, mode(RUN_STOP));
        idle(150);
        b0 = cnt_b;
        bus_wr(OFS_MODE, mode(RUN_RESTART));
        idle(80);
        chk(16'(cnt_b - b0), 16'h0);
        for (int k = 0; k < 2; k++) begin
            bus_wr(OFS_MODE, mode(RUN_STOP));
            bus_wr(OFS_PRESCALE, pre(eg[k], 2'h0));
            w = 40 + ($random(seed) & 63);
            bus_wr(OFS_MODE, mode(RUN_RESTART));
            idle(w);
            partner.set_a(!cap_a);
            wait_b(60, took);
            chk(16'(took < 60), 16'h1);
            bus_rd(OFS_CAPCMP_B, d);
            chk(16'(d >= w / 2 && d <= w / 2 + 8), 16'h1);
            bus_rd(OFS_COUNTER, d);
            chk(16'(d < 16'h10), 16'h1);
        end
        bus_wr(OFS_MODE, mode(RUN_STOP));
        bus_wr(OFS_PRESCALE, pre(EDGE_RISE, 2'h1));
        partner.set_a(1'b0);
        bus_wr(OFS_MODE, mode(RUN_RESTART));
        idle(40);
        b0 = cnt_b;
        partner.pulse_a(3);
        for (int i = 0; i < 20; i++) begin
            bus_rd(OFS_COUNTER, d);
        end
        chk(16'(cnt_b - b0), 16'h0);
        partner.pulse_a(40);
        wait_b(80, took);
        chk(16'(cnt_b - b0), 16'h1);
        bus_wr(OFS_MODE, mode(RUN_STOP));
        bus_wr(OFS_CAPCMP_A, 16'h00A5);
        bus_wr(OFS_PRESCALE, pre(EDGE_BOTH, 2'h0));
        bus_wr(OFS_CC_CTRL, 16'h0007);
        bus_wr(OFS_MODE, mode(RUN_FREE));
        a0 = cnt_a;
        b0 = cnt_b;
        repeat (2) partner.pulse_a(60);
        chk(16'(cnt_a - a0), 16'h0);
        chk(16'(cnt_b - b0), 16'h4);
        bus_rd(OFS_CAPCMP_A, d);
        chk(d, 16'hA5);
        bus_wr(OFS_CC_CTRL, 16'h0000);
        bus_wr(OFS_OUT_CTRL, 16'h0003);
        for (int k = 0; k < 3; k++) begin
            bus_wr(OFS_MODE, mode(RUN_STOP));
            n = 2 + ($random(seed) & 3);
            bus_wr(OFS_CAPCMP_A, 16'(n));
            bus_wr(OFS_PRESCALE, pre(eg[k], CLK_EVENT));
            bus_wr(OFS_MODE, mode(RUN_MATCH_CLEAR));
            a0 = cnt_a;
            repeat ((k == 2 ? 1 : 2) * (n + 1)) partner.pulse_a(16);
            idle(20);
            chk(16'(cnt_a - a0), 16'h2);
            bus_rd(OFS_COUNTER, d);
            chk(d, 16'h0);
            bus_rd(OFS_CAPCMP_A, d);
            chk(d, 16'(n));
            chk(16'(pin_oe_n), 16'h1);
        end
        bus_wr(OFS_MODE, mode(RUN_STOP));
        n = 3 + ($random(seed) & 7);
        bus_wr(OFS_CAPCMP_A, 16'(n));
        bus_wr(OFS_CAPCMP_B, 16'hFFFF);
        bus_wr(OFS_PRESCALE, pre(EDGE_FALL, 2'h0));
        bus_wr(OFS_MODE, mode(RUN_MATCH_CLEAR));
        idle(8 * (n + 1) + 10);
        chk(16'(partner.period), 16'(2 * (n + 1)));
        chk(16'(pin_oe_n), 16'h0);
        bus_wr(OFS_OUT_CTRL, 16'h0001);
        idle(10);
        w = partner.toggles;
        idle(8 * (n + 1));
        chk(16'(partner.toggles - w), 16'h0);
        bus_rd(OFS_CAPCMP_B, d);
        chk(d, 16'hFFFF);
        close_out();
    end
endmodule
